// ### design/swd_ctrl.sv
// Purpose: Sleep mode (halt, stop) and watchdog control with APB status access
// Assumes: Opcode strobes from the core, all inputs synchronous to ref_clk
// Notes:   Watchdog, supply and stop recovery resets are stretched internally
//
// Contract
// - Halt gates core clock only, oscillator and timer keep running
// - Halt exits on a taken interrupt or on a reset
// - Stop gates core clock and oscillator
// - Low recovery pin level resets, restart at 000C
// - Stop recovery keeps port direction settings
// - First 5F enables watchdog, later ones clear
// - Enabled watchdog cannot be disabled until reset
// - Watchdog opcode sets Z, clears S and V
// - Timeout gives power-on reset plus 18 cycles
// - No counting in stop unless permanent option
// - No counting in halt unless 4F given or permanent
// - Opcode 4F keeps watchdog running in halt
// - 4F ignored before watchdog is enabled
// - Low supply detection resets the device
// - Permanent option runs watchdog in every mode
// - Low noise option removes divide-by-two stage
// - Auto latch disable option turns latches off
// - Options sampled once at power-up
`timescale 1ns/1ns

module swd_ctrl
    import swd_pkg::*;
#(
    parameter logic [31:0] WDT_TIMEOUT_TICKS = 32'h00010000
)(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Core opcode strobe and interrupt acceptance
    input  wire logic        op_valid,
    input  wire logic [7:0]  op_code,
    input  wire logic        irq_taken,
    // Pins and supply monitor
    input  wire logic        stop_recovery_pin,
    input  wire logic        supply_low,
    // One-time option bits
    input  wire logic        opt_low_noise,
    input  wire logic        opt_auto_latch_disable,
    input  wire logic        opt_perm_watchdog,
    // Clock and reset control
    output logic             cpu_clk_en,
    output logic             osc_en,
    output logic             timer_clk_en,
    output logic             core_rst_n,
    output logic [11:0]      restart_addr,
    output logic             keep_port_cfg,
    // Flag update to the core
    output logic             flag_upd,
    output logic             flag_z,
    output logic             flag_s,
    output logic             flag_v,
    // Port and latch control
    output logic [7:0]       port2_direction_reg,
    output logic             auto_latch_en
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        swd_mode_t   mode;
        logic        wdt_en;
        logic        wdt_halt;
        logic [31:0] wdt_cnt;
        logic [7:0]  p2_dir;
        logic        opt_done;
        logic        opt_ln;
        logic        opt_ald;
        logic        opt_perm;
        logic [8:0]  rst_cnt;
        swd_cause_t  cause;
        logic        core_rst_n;
        logic        keep_cfg;
        logic [11:0] restart_addr;
        logic        div_ph;
        logic        cpu_clk_en;
        logic        osc_en;
        logic        timer_en;
        logic        flag_upd;
        logic        flag_z;
        logic        flag_s;
        logic        flag_v;
        logic        latch_en;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } swd_state_t;

    swd_state_t st;
    swd_state_t next_st;

    logic       wdt_active;
    logic       wdt_count_ok;
    logic       wdt_timeout;
    logic       op_wdt;
    logic       op_wdh;
    logic       stop_wake;
    logic       apb_setup;
    logic       apb_wr;
    logic [31:0] status_word;
    logic       op_halt;
    logic       op_stop;
    logic       hit_status;
    logic       hit_p2dir;
    logic       hit_wdtcnt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;

        op_wdt     = op_valid && st.core_rst_n && (op_code == OP_WDT);
        op_wdh     = op_valid && st.core_rst_n && (op_code == OP_WDH);
        op_halt    = op_valid && st.core_rst_n && (op_code == OP_HALT);
        op_stop    = op_valid && st.core_rst_n && (op_code == OP_STOP);
        wdt_active = st.wdt_en || st.opt_perm;
        wdt_count_ok = wdt_active && st.core_rst_n &&
                       ((st.mode == MODE_RUN) ||
                        ((st.mode == MODE_HALT) && (st.wdt_halt || st.opt_perm)) ||
                        ((st.mode == MODE_STOP) && st.opt_perm));
        wdt_timeout = wdt_count_ok && (st.wdt_cnt >= WDT_TIMEOUT_TICKS - 32'h1);
        // Pin must be an input and low to release stop
        stop_wake = (st.mode == MODE_STOP) && st.p2_dir[P2DIR_PIN_BIT] && !stop_recovery_pin;

        // ------------------------------------------------------------
        // Options captured once after power-on
        // ------------------------------------------------------------
        if (!st.opt_done) begin
            next_st.opt_done = 1'b1;
            next_st.opt_ln   = opt_low_noise;
            next_st.opt_ald  = opt_auto_latch_disable;
            next_st.opt_perm = opt_perm_watchdog;
        end

        // ------------------------------------------------------------
        // Address decode
        // ------------------------------------------------------------
        hit_status = 1'b0;
        hit_p2dir  = 1'b0;
        hit_wdtcnt = 1'b0;
        if (paddr == REG_STATUS) begin
            hit_status = 1'b1;
        end else if (paddr == REG_P2DIR) begin
            hit_p2dir = 1'b1;
        end else if (paddr == REG_WDTCNT) begin
            hit_wdtcnt = 1'b1;
        end

        // ------------------------------------------------------------
        // APB slave, zero wait states
        // ------------------------------------------------------------
        apb_setup = psel && !penable;
        apb_wr    = psel && penable && st.pready && pwrite;
        status_word = 32'h0;
        status_word[ST_MODE_LSB +: 3]  = st.mode;
        status_word[ST_WDT_EN]         = st.wdt_en;
        status_word[ST_WDT_HALT]       = st.wdt_halt;
        status_word[ST_OPT_LN]         = st.opt_ln;
        status_word[ST_OPT_ALD]        = st.opt_ald;
        status_word[ST_OPT_PERM]       = st.opt_perm;
        status_word[ST_CAUSE_LSB +: 2] = st.cause;
        status_word[ST_IN_RESET]       = !st.core_rst_n;
        next_st.pready = apb_setup;
        if (apb_setup) begin
            next_st.pslverr = !(hit_status || hit_p2dir || hit_wdtcnt);
            next_st.prdata  = 32'h0;
            if (!pwrite && hit_status) begin
                next_st.prdata = status_word;
            end else if (!pwrite && hit_p2dir) begin
                next_st.prdata = {24'h0, st.p2_dir};
            end else if (!pwrite && hit_wdtcnt) begin
                next_st.prdata = st.wdt_cnt;
            end
        end else if (!psel) begin
            next_st.pslverr = 1'b0;
            next_st.prdata  = 32'h0;
        end
        if (apb_wr && hit_p2dir) begin
            next_st.p2_dir = pwdata[7:0];
        end

        // ------------------------------------------------------------
        // Watchdog enable, refresh and halt-run flag
        // ------------------------------------------------------------
        next_st.flag_upd = 1'b0;
        if (op_wdt) begin
            next_st.wdt_en   = 1'b1;
            next_st.flag_upd = 1'b1;
            next_st.flag_z   = 1'b1;
            next_st.flag_s   = 1'b0;
            next_st.flag_v   = 1'b0;
        end
        if (op_wdh && st.wdt_en) begin
            next_st.wdt_halt = 1'b1;
        end
        if (op_wdt && wdt_active) begin
            next_st.wdt_cnt = 32'h0;
        end else if (wdt_count_ok) begin
            next_st.wdt_cnt = st.wdt_cnt + 32'h1;
        end

        // ------------------------------------------------------------
        // Sleep mode sequencing
        // ------------------------------------------------------------
        case (st.mode)
            MODE_RUN: begin
                if (op_halt) begin
                    next_st.mode = MODE_HALT;
                end else if (op_stop) begin
                    next_st.mode = MODE_STOP;
                end
            end
            MODE_HALT: begin
                if (irq_taken) begin
                    next_st.mode = MODE_RUN;
                end
            end
            MODE_STOP: begin
                if (stop_wake) begin
                    next_st.mode     = MODE_RUN;
                    next_st.rst_cnt  = RST_CYC;
                    next_st.cause    = CAUSE_STOP;
                    next_st.keep_cfg = 1'b1;
                end
            end
            default: begin
                next_st.mode = MODE_RUN;
            end
        endcase

        // ------------------------------------------------------------
        // Reset stretch counter
        // ------------------------------------------------------------
        if (st.rst_cnt != 9'h0) begin
            next_st.rst_cnt = st.rst_cnt - 9'h1;
        end

        // ------------------------------------------------------------
        // Watchdog and supply resets clear mode, watchdog and port state, not options or flags
        // ------------------------------------------------------------
        if (wdt_timeout || supply_low) begin
            next_st.rst_cnt  = RST_CYC;
            next_st.cause    = supply_low ? CAUSE_LVD : CAUSE_WDT;
            next_st.mode     = MODE_RUN;
            next_st.wdt_en   = 1'b0;
            next_st.wdt_halt = 1'b0;
            next_st.wdt_cnt  = 32'h0;
            next_st.p2_dir   = P2DIR_RESET;
            next_st.keep_cfg = 1'b0;
        end else if (stop_wake) begin
            next_st.wdt_en   = 1'b0;
            next_st.wdt_halt = 1'b0;
            next_st.wdt_cnt  = 32'h0;
        end

        next_st.core_rst_n   = (next_st.rst_cnt == 9'h0);
        next_st.restart_addr = VEC_RESTART;

        // ------------------------------------------------------------
        // Clock gating and divider
        // ------------------------------------------------------------
        next_st.div_ph     = next_st.opt_ln ? 1'b1 : !st.div_ph;
        next_st.osc_en     = (next_st.mode != MODE_STOP);
        next_st.timer_en   = (next_st.mode != MODE_STOP) && next_st.div_ph;
        next_st.cpu_clk_en = (next_st.mode == MODE_RUN) && next_st.div_ph;
        next_st.latch_en   = !next_st.opt_ald;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st.mode         <= MODE_RUN;
            st.wdt_en       <= 1'b0;
            st.wdt_halt     <= 1'b0;
            st.wdt_cnt      <= 32'h0;
            st.p2_dir       <= P2DIR_RESET;
            st.opt_done     <= 1'b0;
            st.opt_ln       <= 1'b0;
            st.opt_ald      <= 1'b0;
            st.opt_perm     <= 1'b0;
            st.rst_cnt      <= RST_CYC;
            st.cause        <= CAUSE_POR;
            st.core_rst_n   <= 1'b0;
            st.keep_cfg     <= 1'b0;
            st.restart_addr <= VEC_RESTART;
            st.div_ph       <= 1'b0;
            st.cpu_clk_en   <= 1'b0;
            st.osc_en       <= 1'b1;
            st.timer_en     <= 1'b0;
            st.flag_upd     <= 1'b0;
            st.flag_z       <= 1'b0;
            st.flag_s       <= 1'b0;
            st.flag_v       <= 1'b0;
            st.latch_en     <= 1'b1;
            st.pready       <= 1'b0;
            st.prdata       <= 32'h0;
            st.pslverr      <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready              = st.pready;
    assign prdata              = st.prdata;
    assign pslverr             = st.pslverr;
    assign cpu_clk_en          = st.cpu_clk_en;
    assign osc_en              = st.osc_en;
    assign timer_clk_en        = st.timer_en;
    assign core_rst_n          = st.core_rst_n;
    assign restart_addr        = st.restart_addr;
    assign keep_port_cfg       = st.keep_cfg;
    assign flag_upd            = st.flag_upd;
    assign flag_z              = st.flag_z;
    assign flag_s              = st.flag_s;
    assign flag_v              = st.flag_v;
    assign port2_direction_reg = st.p2_dir;
    assign auto_latch_en       = st.latch_en;

endmodule

// ### shared/swd_pkg.sv
// Purpose: Constants and types for the sleep mode and watchdog control block
// Assumes: 250 MHz reference clock, APB register access with 32-bit data
// Notes:   Offsets are byte addresses of aligned words

package swd_pkg;

    // ------------------------------------------------------------
    // Clock and reset timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          POR_DELAY_NS  = 1000;
    localparam int          POR_CYC       = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CRYSTAL_CLOCK_EXTRA    = 18;
    localparam logic [8:0]  RST_CYC       = 9'(POR_CYC + CRYSTAL_CLOCK_EXTRA);

    // ------------------------------------------------------------
    // Core opcodes
    // ------------------------------------------------------------
    localparam logic [7:0]  OP_NOP        = 8'hff;
    localparam logic [7:0]  OP_STOP       = 8'h6f;
    localparam logic [7:0]  OP_HALT       = 8'h7f;
    localparam logic [7:0]  OP_WDT        = 8'h5f;
    localparam logic [7:0]  OP_WDH        = 8'h4f;

    // ------------------------------------------------------------
    // Restart address and port defaults
    // ------------------------------------------------------------
    localparam logic [11:0] VEC_RESTART   = 12'h00c;
    localparam logic [7:0]  P2DIR_RESET   = 8'h00;
    localparam int          P2DIR_PIN_BIT = 7;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_STATUS    = 8'h00;
    localparam logic [7:0]  REG_P2DIR     = 8'h04;
    localparam logic [7:0]  REG_WDTCNT    = 8'h08;

    // Status fields
    localparam int          ST_MODE_LSB   = 0;
    localparam int          ST_WDT_EN     = 3;
    localparam int          ST_WDT_HALT   = 4;
    localparam int          ST_OPT_LN     = 5;
    localparam int          ST_OPT_ALD    = 6;
    localparam int          ST_OPT_PERM   = 7;
    localparam int          ST_CAUSE_LSB  = 8;
    localparam int          ST_IN_RESET   = 10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_RUN  = 3'b001,
        MODE_HALT = 3'b010,
        MODE_STOP = 3'b100
    } swd_mode_t;

    typedef enum logic [1:0] {
        CAUSE_POR  = 2'h0,
        CAUSE_WDT  = 2'h1,
        CAUSE_LVD  = 2'h2,
        CAUSE_STOP = 2'h3
    } swd_cause_t;

endpackage

// ### test/swd_core_model.sv
// Purpose: Core model issuing sleep and watchdog opcodes
// Assumes: Bench holds req until ack is seen high
// Notes:   Idle opcode bus toggles, it carries no meaning
`timescale 1ns/1ns
module swd_core_model
    import swd_pkg::*;
(
    // Clock and resets
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       core_rst_n,
    // Bench request
    input  wire logic       req,
    input  wire logic [7:0] req_op,
    output logic            ack,
    // Opcode strobe
    output logic            op_valid,
    output logic [7:0]      op_code
);
    logic nop_done;

    always_ff @(posedge ref_clk) begin
        op_valid <= 1'h0;
        ack      <= 1'h0;
        op_code  <= ~op_code;
        if (!rstn || !core_rst_n) begin
            nop_done <= 1'h0;
            op_code  <= 8'h00;
        end else if (req && !ack) begin
            op_valid <= 1'h1;
            if ((req_op == OP_STOP || req_op == OP_HALT) && !nop_done) begin
                op_code  <= OP_NOP;
                nop_done <= 1'h1;
            end else begin
                op_code  <= req_op;
                ack      <= 1'h1;
                nop_done <= 1'h0;
            end
        end
    end
endmodule

// ### test/swd_ctrl_properties.sv
// Purpose: Concurrent checks on the sleep and watchdog control ports
// Assumes: One ref_clk domain, rstn synchronous active low
// Notes:   Bound to every swd_ctrl instance
`timescale 1ns/1ns
module swd_ctrl_properties
    import swd_pkg::*;
#(
    parameter logic [31:0] WDT_TIMEOUT_TICKS = 32'h00010000
)(
    // Clock, reset, core side
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        op_valid,
    input wire logic [7:0]  op_code,
    input wire logic        irq_taken,
    input wire logic        stop_recovery_pin,
    input wire logic        supply_low,
    // Block outputs
    input wire logic        cpu_clk_en,
    input wire logic        osc_en,
    input wire logic        timer_clk_en,
    input wire logic        core_rst_n,
    input wire logic [11:0] restart_addr,
    input wire logic        keep_port_cfg,
    input wire logic        flag_upd,
    input wire logic        flag_z,
    input wire logic        flag_s,
    input wire logic        flag_v,
    input wire logic [7:0]  port2_direction_reg,
    input wire logic        auto_latch_en
);
    localparam int LO = RST_CYC - 1;
    localparam int HI = RST_CYC + 1;
    logic [8:0] low_cnt;
    logic       skip;
    logic       asleep;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // Reset length and halt tracking
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            low_cnt <= 9'h000;
            skip    <= 1'h1;
            asleep  <= 1'h0;
        end else begin
            low_cnt <= core_rst_n ? 9'h000 : low_cnt + 9'h001;
            skip    <= !core_rst_n && (skip || supply_low);
            asleep  <= core_rst_n && !irq_taken && (asleep || (op_valid && op_code == OP_HALT && osc_en));
        end
    end

    property p_flags;
        op_valid && op_code == OP_WDT && core_rst_n |=> flag_upd && flag_z && !flag_s && !flag_v;
    endproperty
    a_flags: assert property (p_flags)
        else $error("watchdog op flags wrong");
    property p_halt;
        asleep && $past(asleep) && core_rst_n |-> !cpu_clk_en && osc_en && (timer_clk_en || $past(timer_clk_en));
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt clock gating wrong");
    property p_wake;
        asleep && irq_taken |-> ##[1:4] cpu_clk_en;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake after interrupt");
    property p_stop;
        op_valid && op_code == OP_STOP && core_rst_n && stop_recovery_pin |=> !osc_en ##1 (!osc_en && !cpu_clk_en);
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not gate clocks");
    property p_recov;
        !osc_en && !stop_recovery_pin && port2_direction_reg[7]
            |=> !core_rst_n && keep_port_cfg && restart_addr == VEC_RESTART;
    endproperty
    a_recov: assert property (p_recov)
        else $error("pin recovery reset wrong");
    property p_keep;
        !osc_en && !stop_recovery_pin && port2_direction_reg[7] |=> $stable(port2_direction_reg) [*3];
    endproperty
    a_keep: assert property (p_keep)
        else $error("port direction lost on recovery");
    property p_len;
        $rose(core_rst_n) && !skip |-> low_cnt inside {[LO:HI]};
    endproperty
    a_len: assert property (p_len)
        else $error("reset stretch length wrong");
    property p_lvd;
        supply_low |=> !core_rst_n;
    endproperty
    a_lvd: assert property (p_lvd)
        else $error("low supply did not reset");
    property p_opt;
        $past(rstn, 3) |-> $stable(auto_latch_en);
    endproperty
    a_opt: assert property (p_opt)
        else $error("option changed after power-up");

    c_wake: cover property (asleep && irq_taken);
    c_recov: cover property (!osc_en && !stop_recovery_pin);
    c_len: cover property ($rose(core_rst_n) && !skip);
endmodule

bind swd_ctrl swd_ctrl_properties #(.WDT_TIMEOUT_TICKS(WDT_TIMEOUT_TICKS)) swd_ctrl_properties_i (
    .ref_clk, .rstn, .op_valid, .op_code, .irq_taken, .stop_recovery_pin, .supply_low, .cpu_clk_en,
    .osc_en, .timer_clk_en, .core_rst_n, .restart_addr, .keep_port_cfg, .flag_upd, .flag_z, .flag_s,
    .flag_v, .port2_direction_reg, .auto_latch_en
);

// ### test/tb_top.sv
// Purpose: Self-checking bench for the sleep mode and watchdog control block
// Assumes: Core model issues opcodes, bench is the APB master
// Notes:   Watchdog timeout shortened to 64 ticks
`timescale 1ns/1ns
module tb_top import swd_pkg::*;;
    logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, irq_taken;
    logic        stop_recovery_pin, supply_low, opt_low_noise, opt_auto_latch_disable;
    logic        opt_perm_watchdog, cpu_clk_en, osc_en, timer_clk_en, core_rst_n;
    logic        keep_port_cfg, flag_upd, flag_z, flag_s, flag_v, auto_latch_en;
    logic        op_valid, req, ack, perr;
    logic [7:0]  paddr, op_code, port2_direction_reg, req_op;
    logic [11:0] restart_addr;
    logic [31:0] pwdata, prdata, q, pv;
    int          err_total, n_tests;

    swd_ctrl #(.WDT_TIMEOUT_TICKS(32'h00000040)) swd_ctrl_i (.*);
    swd_core_model swd_core_model_i (.*);

    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end

    task summarize;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task tmo(input int k);
        if (k >= 3000) begin
            err_total++;
            summarize;
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'h1 && k < 3000);
        q = prdata;
        perr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        tmo(k);
    endtask

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(nm, e, q & m);
    endtask

    task op(input logic [7:0] x);
        int k;
        k = 0;
        @(posedge ref_clk);
        req <= 1'h1;
        req_op <= x;
        do begin
            @(posedge ref_clk);
            k++;
        end while (ack !== 1'h1 && k < 3000);
        req <= 1'h0;
        tmo(k);
    endtask

    task wr(input logic v);
        int k;
        k = 0;
        while (core_rst_n !== v && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
        tmo(k);
    endtask

    initial begin
        {rstn, psel, penable, pwrite, irq_taken, supply_low, req} = 7'h00;
        {opt_low_noise, opt_auto_latch_disable, opt_perm_watchdog} = 3'h0;
        {err_total, n_tests, paddr, pwdata, req_op} = '0;
        stop_recovery_pin = 1'h1;
        cyc(5);
        rstn <= 1'h1;
        wr(1'h1);
        rdc("status", REG_STATUS, 32'h7ff, 32'h1);
        apb(1'h1, REG_STATUS, 32'hffffffff);
        rdc("status_ro", REG_STATUS, 32'h7ff, 32'h1);
        apb(1'h0, 8'h0c, 32'h0);
        chk("unmapped", 32'h1, 32'(perr));
        apb(1'h1, REG_P2DIR, 32'hffffff80);
        rdc("p2dir", REG_P2DIR, 32'hffffffff, 32'h80);
        op(OP_WDH);
        rdc("wdh_early", REG_STATUS, 32'h7ff, 32'h1);
        op(OP_WDT);
        rdc("wdt_on", REG_STATUS, 32'h7ff, 32'h9);
        chk("flags", 32'h4, {29'h0, flag_z, flag_s, flag_v});
        cyc(20);
        op(OP_WDT);
        apb(1'h0, REG_WDTCNT, 32'h0);
        chk("wdt_clear", 32'h1, 32'(q < 32'h10));
        op(OP_HALT);
        apb(1'h0, REG_WDTCNT, 32'h0);
        pv = q;
        cyc(100);
        rdc("halt_cnt", REG_WDTCNT, 32'hffffffff, pv);
        rdc("halt_mode", REG_STATUS, 32'h7ff, 32'ha);
        chk("halt_alive", 32'h1, 32'(core_rst_n));
        irq_taken <= 1'h1;
        cyc(1);
        irq_taken <= 1'h0;
        op(OP_WDT);
        rdc("wake", REG_STATUS, 32'h7ff, 32'h9);
        op(OP_WDH);
        rdc("wdh_on", REG_STATUS, 32'h7ff, 32'h19);
        op(OP_NOP);
        rdc("wdt_kept", REG_STATUS, 32'h8, 32'h8);
        op(OP_HALT);
        wr(1'h0);
        wr(1'h1);
        rdc("wdt_rst", REG_STATUS, 32'h7ff, 32'h101);
        apb(1'h1, REG_P2DIR, 32'h85);
        op(OP_WDT);
        op(OP_STOP);
        cyc(100);
        chk("stop_alive", 32'h1, 32'(core_rst_n));
        rdc("stop_mode", REG_STATUS, 32'h7ff, 32'h10c);
        stop_recovery_pin <= 1'h0;
        wr(1'h0);
        stop_recovery_pin <= 1'h1;
        wr(1'h1);
        rdc("stop_rec", REG_STATUS, 32'h7ff, 32'h301);
        rdc("stop_p2", REG_P2DIR, 32'hff, 32'h85);
        chk("vec", 32'hc, 32'(restart_addr));
        chk("keep", 32'h1, 32'(keep_port_cfg));
        supply_low <= 1'h1;
        cyc(5);
        supply_low <= 1'h0;
        wr(1'h1);
        rdc("lvd", REG_STATUS, 32'h7ff, 32'h201);
        chk("keep_clr", 32'h0, 32'(keep_port_cfg));
        rstn <= 1'h0;
        {opt_low_noise, opt_auto_latch_disable, opt_perm_watchdog} <= 3'h7;
        cyc(5);
        rstn <= 1'h1;
        cyc(2);
        {opt_low_noise, opt_auto_latch_disable, opt_perm_watchdog} <= 3'h0;
        wr(1'h1);
        rdc("opts", REG_STATUS, 32'h7f7, 32'he1);
        chk("latch", 32'h0, 32'(auto_latch_en));
        repeat (2) begin
            cyc(1);
            chk("low_noise", 32'h1, 32'(cpu_clk_en));
        end
        wr(1'h0);
        wr(1'h1);
        rdc("perm_rst", REG_STATUS, 32'h7e0, 32'h1e0);
        summarize;
    end
endmodule
